// file: include/outch_pkg.sv
// constants for one output channel: source select, divider and driver setup
// assumes a 100 MHz system clock and an apb register port with 32-bit data
package outch_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [7:0] output_five_control_idx = 8'h27;
    localparam logic [7:0] output_five_divider_idx = 8'h28;
    localparam logic [7:0] channel_config_idx = 8'h29;
    localparam logic [7:0] channel_status_idx = 8'h2A;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] source_select_reset = 2'h0;
    localparam logic [1:0] driver_type_reset = 2'h1;
    localparam logic [1:0] mode_positive_reset = 2'h2;
    localparam logic [1:0] mode_negative_reset = 2'h0;
    localparam logic [7:0] divider_reset = 8'h02;
    localparam logic doubler_reset = 1'b0;

    // ------------------------------------------------------------------
    // field positions in the control and channel config registers
    // ------------------------------------------------------------------
    localparam int source_select_lsb = 6;
    localparam int driver_type_lsb = 4;
    localparam int mode_positive_lsb = 2;
    localparam int mode_negative_lsb = 0;
    localparam int doubler_bit = 0;

    // ------------------------------------------------------------------
    // source select codes
    // ------------------------------------------------------------------
    localparam logic [1:0] source_pll1 = 2'h0;
    localparam logic [1:0] source_pll2 = 2'h1;
    localparam logic [1:0] source_ref_primary = 2'h2;
    localparam logic [1:0] source_ref_secondary = 2'h3;

    // ------------------------------------------------------------------
    // driver type codes
    // ------------------------------------------------------------------
    localparam logic [1:0] driver_disabled = 2'h0;
    localparam logic [1:0] driver_ac_diff = 2'h1;
    localparam logic [1:0] driver_hcsl = 2'h2;
    localparam logic [1:0] driver_cmos = 2'h3;

    // ------------------------------------------------------------------
    // cmos per-pin mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] pin_off_tristate = 2'h0;
    localparam logic [1:0] pin_off_low = 2'h1;
    localparam logic [1:0] pin_on_inverted = 2'h2;
    localparam logic [1:0] pin_on_true = 2'h3;

    // ------------------------------------------------------------------
    // source synchroniser depth
    // ------------------------------------------------------------------
    localparam int sync_stages = 2;

endpackage : outch_pkg

// file: rtl/output_divider.sv
// programmable output divider for one channel, ratio = field + 1
// assumes source_rise is a one-cycle pulse on each rising source edge
`timescale 1ns/10ps
`default_nettype none

module output_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic source_level,
    input wire logic source_rise,
    input wire logic bypass,
    input wire logic [7:0] ratio_field,
    output logic divided_level
);

    logic [7:0] count;
    logic [8:0] half;
    logic high_phase;

    // ceil of ratio over two: high part of each divided period
    assign half = ({1'b0, ratio_field} + 9'h002) >> 1;
    assign high_phase = {1'b0, count} < half;

    // ------------------------------------------------------------------
    // count source edges, wrap at the field value
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 8'h00;
        end else if (bypass) begin
            count <= 8'h00;
        end else if (source_rise) begin
            if (count >= ratio_field) begin
                count <= 8'h00;
            end else begin
                count <= count + 8'h01;
            end
        end
    end

    // reference sources and ratio 1 pass the source level through
    always_comb begin
        if (bypass || ratio_field == 8'h00) begin
            divided_level = source_level;
        end else begin
            divided_level = high_phase;
        end
    end

endmodule : output_divider

`default_nettype wire

// file: rtl/output_channel.sv
// one output channel: apb registers, source select, divider, driver setup
// assumes clock sources arrive asynchronously and are much slower than clk
// pin outputs and the bus answer come straight from flip-flops
//
// Contract
// - source select: 0 pll1, 1 pll2, 2 primary ref, 3 secondary ref
// - with doubler on, a selected reference is frequency doubled
// - a reference source bypasses the output divider
// - divider field is eight bits in its own register, reset 0x02
// - divide ratio is divider field plus one, 1 to 256
// - divider acts only when pll1 or pll2 is the source
// - driver type: 0 off, 1 ac differential, 2 hcsl, 3 cmos; reset 1
// - cmos positive pin: off-tristate, off-low, inverted, true; reset 2
// - negative pin same codes in cmos, hcsl load select; reset 0
`timescale 1ns/10ps
`default_nettype none

module output_channel (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll1_clk,
    input wire logic pll2_clk,
    input wire logic ref_primary,
    input wire logic ref_secondary,
    output logic out_p,
    output logic out_p_oe_n,
    output logic out_n,
    output logic out_n_oe_n,
    output logic [1:0] tail_current_select,
    output logic [1:0] load_select
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // per-pin drive for a cmos mode code: {oe_n, level}
    function automatic logic [1:0] pin_drive(input logic [1:0] mode,
                                             input logic level);
        logic [1:0] r;
        r = 2'b10;
        unique case (mode)
            outch_pkg::pin_off_tristate: r = 2'b10;
            outch_pkg::pin_off_low: r = 2'b00;
            outch_pkg::pin_on_inverted: r = {1'b0, ~level};
            outch_pkg::pin_on_true: r = {1'b0, level};
        endcase
        return r;
    endfunction : pin_drive

    // byte address to register index, flags misaligned
    function automatic logic [8:0] reg_index(input logic [11:0] addr);
        return {addr[1:0] != 2'b00, addr[9:2]};
    endfunction : reg_index

    // true when an aligned index selects the given register
    function automatic logic reg_hit(input logic [8:0] idx,
                                     input logic [7:0] target);
        return idx == {1'b0, target};
    endfunction : reg_hit

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // register fields as software sees them
    logic [1:0] channel_source_select;
    logic [1:0] driver_type;
    logic [1:0] driver_mode_positive;
    logic [1:0] driver_mode_negative;
    logic [7:0] output_five_divider;
    logic doubler_enable;

    // decode of the current transfer
    logic [8:0] index;
    logic setup_phase;
    logic write_access;
    logic mapped;

    // address index and bus phase of the transfer
    assign index = reg_index(paddr);
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite && pready;
    // mapped: aligned and inside this block's four registers
    assign mapped = (index[8] == 1'b0) && (paddr[11:10] == 2'b00) &&
                    (index[7:0] >= outch_pkg::output_five_control_idx) &&
                    (index[7:0] <= outch_pkg::channel_status_idx);

    // control register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_source_select <= outch_pkg::source_select_reset;
            driver_type <= outch_pkg::driver_type_reset;
            driver_mode_positive <= outch_pkg::mode_positive_reset;
            driver_mode_negative <= outch_pkg::mode_negative_reset;
        end else if (write_access && mapped &&
                     reg_hit(index, outch_pkg::output_five_control_idx)) begin
            channel_source_select <=
                pwdata[outch_pkg::source_select_lsb +: 2];
            driver_type <= pwdata[outch_pkg::driver_type_lsb +: 2];
            driver_mode_positive <= pwdata[outch_pkg::mode_positive_lsb +: 2];
            driver_mode_negative <= pwdata[outch_pkg::mode_negative_lsb +: 2];
        end
    end

    // divider register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_five_divider <= outch_pkg::divider_reset;
        end else if (write_access && mapped &&
                     reg_hit(index, outch_pkg::output_five_divider_idx)) begin
            output_five_divider <= pwdata[7:0];
        end
    end

    // channel configuration writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            doubler_enable <= outch_pkg::doubler_reset;
        end else if (write_access && mapped &&
                     reg_hit(index, outch_pkg::channel_config_idx)) begin
            doubler_enable <= pwdata[outch_pkg::doubler_bit];
        end
    end

    // ------------------------------------------------------------------
    // source synchronisers and edge detection
    // ------------------------------------------------------------------
    // synchroniser stages, one bit per source
    logic [3:0] sync_first;
    logic [3:0] sync_second;
    logic [3:0] sync_last;
    logic [3:0] src_rise;
    logic [3:0] src_edge;

    // two flip-flops per asynchronous source, then one for edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_first <= 4'h0;
            sync_second <= 4'h0;
            sync_last <= 4'h0;
        end else begin
            sync_first <= {ref_secondary, ref_primary, pll2_clk, pll1_clk};
            sync_second <= sync_first;
            sync_last <= sync_second;
        end
    end

    // rising and any edge of each synchronised source
    assign src_rise = sync_second & ~sync_last;
    assign src_edge = sync_second ^ sync_last;

    // ------------------------------------------------------------------
    // source select and reference doubler
    // ------------------------------------------------------------------
    // selected source and its doubled form
    logic is_reference;
    logic doubled;
    logic raw_level;
    logic raw_rise;
    logic raw_edge;
    logic source_level;
    logic source_rise;
    logic double_pulse;

    // route the selected source; codes 2 and 3 are references
    assign is_reference = channel_source_select[1];
    assign doubled = is_reference && doubler_enable;
    assign raw_level = sync_second[channel_source_select];
    assign raw_rise = src_rise[channel_source_select];
    assign raw_edge = src_edge[channel_source_select];

    // doubled reference: one high cycle after every reference edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            double_pulse <= 1'b0;
        end else begin
            double_pulse <= doubled && raw_edge;
        end
    end

    // doubled reference replaces the raw level and its edges
    assign source_level = doubled ? double_pulse : raw_level;
    assign source_rise = doubled ? (raw_edge && !double_pulse) : raw_rise;

    // ------------------------------------------------------------------
    // output divider
    // ------------------------------------------------------------------
    // divided or bypassed level from the divider
    logic divided_level;

    output_divider divider_inst (
        .clk(clk),
        .rst(rst),
        .source_level(source_level),
        .source_rise(source_rise),
        .bypass(is_reference),
        .ratio_field(output_five_divider),
        .divided_level(divided_level)
    );

    // ------------------------------------------------------------------
    // driver encoding
    // ------------------------------------------------------------------
    // next pin drive codes {oe_n, level}, then tail and load select codes
    logic [1:0] next_pos;
    logic [1:0] next_neg;
    logic [1:0] next_tail;
    logic [1:0] next_load;

    // pin drive per driver type
    always_comb begin
        next_pos = 2'b10;
        next_neg = 2'b10;
        next_tail = 2'h0;
        next_load = 2'h0;
        unique case (driver_type)
            outch_pkg::driver_disabled: begin
                next_pos = 2'b10;
                next_neg = 2'b10;
            end
            outch_pkg::driver_ac_diff: begin
                next_pos = {1'b0, divided_level};
                next_neg = {1'b0, ~divided_level};
                next_tail = driver_mode_positive;
            end
            outch_pkg::driver_hcsl: begin
                next_pos = {1'b0, divided_level};
                next_neg = {1'b0, ~divided_level};
                next_tail = driver_mode_positive;
                next_load = driver_mode_negative;
            end
            outch_pkg::driver_cmos: begin
                next_pos = pin_drive(driver_mode_positive,
                                     divided_level);
                next_neg = pin_drive(driver_mode_negative,
                                     divided_level);
            end
        endcase
    end

    // registered pin outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_p <= 1'b0;
            out_p_oe_n <= 1'b1;
            out_n <= 1'b0;
            out_n_oe_n <= 1'b1;
            tail_current_select <= 2'h0;
            load_select <= 2'h0;
        end else begin
            out_p_oe_n <= next_pos[1];
            out_p <= next_pos[0];
            out_n_oe_n <= next_neg[1];
            out_n <= next_neg[0];
            tail_current_select <= next_tail;
            load_select <= next_load;
        end
    end

    // ------------------------------------------------------------------
    // apb read path, zero wait states
    // ------------------------------------------------------------------
    // read data of the addressed register
    logic [31:0] next_rdata;

    // read mux for the addressed register
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (index[7:0] == outch_pkg::output_five_control_idx) begin
            next_rdata[7:0] = {channel_source_select, driver_type,
                               driver_mode_positive, driver_mode_negative};
        end else if (index[7:0] == outch_pkg::output_five_divider_idx) begin
            next_rdata[7:0] = output_five_divider;
        end else if (index[7:0] == outch_pkg::channel_config_idx) begin
            next_rdata[0] = doubler_enable;
        end else if (index[7:0] == outch_pkg::channel_status_idx) begin
            next_rdata[2:0] = {doubled, divided_level, is_reference};
        end
    end

    // data and error are captured in the setup cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b1;
        end else begin
            pready <= 1'b1;
            if (setup_phase) begin
                prdata <= (mapped && !pwrite) ? next_rdata : 32'h0000_0000;
                pslverr <= !mapped;
            end
        end
    end

endmodule : output_channel

`default_nettype wire

// file: verification/output_channel_monitor.sv
// checker for output_channel: pin setup against the control register
// assumes apb writes land at the access edge with pready high
`timescale 1ns/10ps
`default_nettype none
module output_channel_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic out_p,
    input wire logic out_p_oe_n,
    input wire logic out_n,
    input wire logic out_n_oe_n,
    input wire logic [1:0] tail_current_select,
    input wire logic [1:0] load_select
);
    logic [7:0] ctl;
    logic [1:0] ty;
    logic [1:0] mp;
    logic [1:0] mn;
    // ------------------------------------------------------------
    // shadow of the control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl <= 8'h18;
        end else if (psel && penable && pwrite && pready
                     && paddr == 12'h09C) begin
            ctl <= pwdata[7:0];
        end
    end
    // field views
    assign ty = ctl[5:4];
    assign mp = ctl[3:2];
    assign mn = ctl[1:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_type_off: assert property (
        (ty == 2'h0) [*3] |-> out_p_oe_n && out_n_oe_n)
        else $error("disabled driver still drives");
    a_diff_pair: assert property (
        (ty == 2'h1 || ty == 2'h2) [*3] |-> !out_p_oe_n && !out_n_oe_n
        && out_n != out_p) else $error("differential pair broken");
    a_tail_code: assert property (
        (ty == 2'h1) [*3] |-> tail_current_select == $past(mp)
        && load_select == 2'h0) else $error("tail code wrong");
    a_hcsl_load: assert property (
        (ty == 2'h2) [*3] |-> load_select == $past(mn)
        && tail_current_select == $past(mp))
        else $error("load select wrong");
    a_pos_float: assert property (
        (ty == 2'h3 && mp == 2'h0) [*3] |-> out_p_oe_n)
        else $error("positive pin not floating");
    a_pos_low: assert property (
        (ty == 2'h3 && mp == 2'h1) [*3] |-> !out_p_oe_n && !out_p)
        else $error("positive pin not low");
    a_neg_low: assert property (
        (ty == 2'h3 && mn == 2'h1) [*3] |-> !out_n_oe_n && !out_n)
        else $error("negative pin not low");
    a_cmos_polar: assert property (
        (ty == 2'h3 && mp == 2'h2 && mn == 2'h3) [*3] |-> out_p != out_n)
        else $error("pin polarity wrong");
    a_ctl_read: assert property (
        psel && !penable && !pwrite && paddr == 12'h09C
        |=> prdata == {24'h0, ctl}) else $error("control read wrong");
endmodule : output_channel_monitor
bind output_channel output_channel_monitor mon (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .out_p, .out_p_oe_n, .out_n,
    .out_n_oe_n, .tail_current_select, .load_select);
`default_nettype wire

// file: verification/tb_output_channel.sv
// self-checking bench for output_channel over apb
// assumes the monitor is bound in; sources run from counters of clk
`timescale 1ns/10ps
`default_nettype none
module tb_output_channel;
    localparam logic [11:0] a_ctl =
        {2'h0, outch_pkg::output_five_control_idx, 2'h0};
    localparam logic [11:0] a_div =
        {2'h0, outch_pkg::output_five_divider_idx, 2'h0};
    localparam logic [11:0] a_cfg =
        {2'h0, outch_pkg::channel_config_idx, 2'h0};
    localparam logic [11:0] a_sta =
        {2'h0, outch_pkg::channel_status_idx, 2'h0};
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic err, pll1_clk = 0, pll2_clk = 0, ref_primary = 0, ref_secondary = 0;
    logic out_p, out_p_oe_n, out_n, out_n_oe_n;
    logic [1:0] tail_current_select, load_select;
    int n_fail = 0, compares = 0, cycles = 0, src = 0;
    output_channel dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pll1_clk, .pll2_clk,
        .ref_primary, .ref_secondary, .out_p, .out_p_oe_n, .out_n,
        .out_n_oe_n, .tail_current_select, .load_select);
    // clock
    initial forever #5 clk = ~clk;
    // source waveforms with periods of 8, 10, 12 and 14 clk cycles
    always @(posedge clk) begin
        src <= src + 1;
        pll1_clk <= (src % 8) < 4;
        pll2_clk <= (src % 10) < 5;
        ref_primary <= (src % 12) < 6;
        ref_secondary <= (src % 14) < 7;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            print_verdict;
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rise(output int c);
        c = 0;
        while (out_p !== 1'b0 && c < 5000) begin
            @(posedge clk);
            c++;
        end
        while (out_p !== 1'b1 && c < 5000) begin
            @(posedge clk);
            c++;
        end
    endtask : rise
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        apb(1'b0, a_ctl, 32'h0);
        chk(rd, 32'h18);
        apb(1'b0, a_div, 32'h0);
        chk(rd, 32'h02);
        apb(1'b0, 12'h000, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_reset
    task automatic t_regs;
        apb(1'b1, a_div, 32'hFFFF_FFFF);
        apb(1'b0, a_div, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b1, a_ctl, 32'h1234_56A5);
        apb(1'b0, a_ctl, 32'h0);
        chk(rd, 32'hA5);
        apb(1'b1, 12'hFFC, 32'h5A);
        chk({31'h0, err}, 32'h1);
    endtask : t_regs
    task automatic t_pins;
        logic [7:0] tv [6] = '{8'h0F, 8'h2B, 8'h1E, 8'h35, 8'h31, 8'h3B};
        logic [5:0] te [6] = '{6'h30, 6'h0B, 6'h0C, 6'h00, 6'h20, 6'h00};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, a_ctl, {24'h0, tv[i]});
            repeat (4) @(posedge clk);
            chk({26'h0, out_p_oe_n, out_n_oe_n, tail_current_select,
                 load_select}, {26'h0, te[i]});
        end
    endtask : t_pins
    task automatic t_period;
        logic [1:0] ts [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
        logic [7:0] td [8] = '{8'h00, 8'h02, 8'hFF, 8'h01, 8'h05, 8'h05,
                              8'h05, 8'h05};
        logic tc [8] = '{0, 0, 0, 0, 0, 0, 1, 1};
        int tp [8] = '{8, 24, 2048, 20, 12, 14, 6, 7};
        int c;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, a_cfg, {31'h0, tc[i]});
            apb(1'b1, a_div, {24'h0, td[i]});
            apb(1'b1, a_ctl, {24'h0, ts[i], 6'h3F});
            apb(1'b0, a_sta, 32'h0);
            chk({29'h0, rd[2], 1'b0, rd[0]},
                {29'h0, tc[i] & ts[i][1], 1'b0, ts[i][1]});
            rise(c);
            rise(c);
            rise(c);
            chk(32'(c), 32'(tp[i]));
        end
    endtask : t_period
    task automatic print_verdict;
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_regs;
        t_pins;
        t_period;
        print_verdict;
    end
endmodule : tb_output_channel
`default_nettype wire
